// [logic/svm_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Single clock; ready and empty come straight from flip-flops.
`timescale 1ns/1ps
module svm_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic room_r, room_nxt, empty_r, empty_nxt;
    logic push, pop;

    always_comb begin
        push = in_valid_i & room_r;
        pop = out_ready_i & ~empty_r;
        wr_nxt = push ? ((wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1) : wr_r;
        rd_nxt = pop ? ((rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1) : rd_r;
        cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
        // Ready is kept as its own flop so the port needs no inverter
        room_nxt = (cnt_nxt != (AW + 1)'(DEPTH));
        empty_nxt = (cnt_nxt == '0);
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
            room_r <= 1'b1;
            empty_r <= 1'b1;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
            room_r <= room_nxt;
            empty_r <= empty_nxt;
        end
    end

    // Storage needs no reset; empty_r hides stale words
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_r] <= in_data_i;
        end
    end

    assign in_ready_o = room_r;
    assign out_valid_o = ~empty_r;
    assign out_data_o = mem[rd_r];

endmodule // svm_fifo

// [logic/svm_map.svh]
// Constants for the space vector PWM modulator: arithmetic, reset values.
// Included by the modulator design file; definitions only.
`ifndef SVM_MAP_SVH
`define SVM_MAP_SVH

// 2/sqrt(3) in Q15: 1.1547 * 32768
`define SVM_K_INV 36'sh0000093CD
`define SVM_K_SHIFT 15
`define SVM_BIAS_SHIFT 15
`define SVM_GAIN_SHIFT 1
`define SVM_DIV_SHIFT 16
`define SVM_OUT_MAX 36'sh000007FFF
`define SVM_OUT_MIN -36'sh000008000
`define SVM_FIFO_DEPTH 8
`define SVM_RST_COUNT 16'h0000
`define SVM_RST_DEAD 8'h00

`endif

// [logic/svm_pkg.sv]
// Types shared by the space vector PWM modulator and its bench.
// Assumes svm_map.svh holds the numeric constants.
package svm_pkg;

    typedef struct packed {
        logic signed [15:0] va;
        logic signed [15:0] vb;
        logic signed [15:0] vc;
    } svm_phase_t;

    // Element 0 is leg a, 1 is leg b, 2 is leg c
    typedef logic [2:0][15:0] svm_duty_t;

    typedef struct packed {
        logic [2:0] hi;
        logic [2:0] lo;
    } svm_gate_t;

    typedef enum logic [1:0] {
        SVM_IDLE,
        SVM_START,
        SVM_RUN,
        SVM_FAULT
    } svm_state_t;

endpackage

// [logic/svm_pwm_modulator.sv]
// Space vector modulation, PWM scaling, centre-aligned three-leg PWM
// with dead time, and the motor sequencer that gates it.
// Assumes phase commands and control strobes come from logic on sys_clk_i.
`timescale 1ns/1ps
`include "svm_map.svh"

// Summary of operation
// - Offset is half of min plus max
// - Subtract offset, scale by two over root three
// - Sine mode bypasses offset injection
// - Output is period*32768 plus gain*v/2, over 65536
// - Centre-aligned PWM duty from scaled value
// - Six gates, high and low per leg
// - Low side complements high side
// - Dead time; both sides never on
// - Sequencer handles start, stop, fault, clear
// - Sequencer triggers ADC, enables PWM and regulators
module svm_pwm_modulator (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ph_valid_i,
    input wire svm_pkg::svm_phase_t ph_i,
    output logic ph_ready_o,
    input wire logic svm_en_i,
    input wire logic [15:0] pwm_period_i,
    input wire logic [15:0] pwm_gain_i,
    input wire logic [7:0] dead_time_i,
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic fault_i,
    input wire logic fault_clr_i,
    output svm_pkg::svm_gate_t gate_o,
    output logic adc_trig_o,
    output logic pwm_en_o,
    output logic cur_pi_en_o,
    output logic spd_pi_en_o,
    output svm_pkg::svm_state_t state_o
);
    import svm_pkg::*;

    function automatic logic signed [15:0] inject(input logic signed [15:0] v,
                                                  input logic signed [16:0] off);
        logic signed [35:0] d;
        logic signed [35:0] q;
        d = 36'(v) - 36'(off);
        q = (d * `SVM_K_INV) >>> `SVM_K_SHIFT;
        if (q > `SVM_OUT_MAX) begin
            inject = 16'sh7FFF;
        end else if (q < `SVM_OUT_MIN) begin
            inject = 16'sh8000;
        end else begin
            inject = q[15:0];
        end
    endfunction

    function automatic logic [15:0] scale(input logic signed [15:0] v,
                                          input logic [15:0] per,
                                          input logic [15:0] gain);
        logic signed [35:0] a;
        logic signed [35:0] s;
        a = 36'(signed'({1'b0, per})) <<< `SVM_BIAS_SHIFT;
        s = (a + ((36'(signed'({1'b0, gain})) * 36'(v)) >>> `SVM_GAIN_SHIFT))
            >>> `SVM_DIV_SHIFT;
        // Clamp keeps an over-driven gain from wrapping the duty
        if (s < 36'sh0) begin
            scale = 16'h0000;
        end else if (s > 36'(signed'({1'b0, per}))) begin
            scale = per;
        end else begin
            scale = s[15:0];
        end
    endfunction

    logic signed [15:0] vmin, vmax;
    logic signed [16:0] voff;
    logic signed [15:0] vsel [3];
    logic signed [15:0] vraw [3];
    svm_duty_t duty_w, cmp_r, cmp_nxt, fifo_q;
    logic fifo_valid;
    logic [15:0] cnt_r, cnt_nxt, per_r, per_nxt;
    logic up_r, up_nxt, valley_w;

    always_comb begin
        vraw[0] = ph_i.va;
        vraw[1] = ph_i.vb;
        vraw[2] = ph_i.vc;
        vmin = vraw[0];
        vmax = vraw[0];
        for (int i = 1; i < 3; i++) begin
            if (vraw[i] < vmin) vmin = vraw[i];
            if (vraw[i] > vmax) vmax = vraw[i];
        end
        voff = (17'(vmin) + 17'(vmax)) >>> 1;
        for (int i = 0; i < 3; i++) begin
            vsel[i] = svm_en_i ? inject(vraw[i], voff) : vraw[i];
            duty_w[i] = scale(vsel[i], pwm_period_i, pwm_gain_i);
        end
    end

    // Duties queue here so a burst of samples waits for the next valley
    svm_fifo #(
        .WIDTH(48),
        .DEPTH(`SVM_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .in_valid_i(ph_valid_i),
        .in_ready_o(ph_ready_o),
        .in_data_i(duty_w),
        .out_valid_o(fifo_valid),
        .out_ready_i(valley_w),
        .out_data_o(fifo_q)
    );

    // Carrier

    always_comb begin
        valley_w = (cnt_r == 16'h0000) && (!up_r || per_r == 16'h0000);
        cnt_nxt = cnt_r;
        up_nxt = up_r;
        per_nxt = valley_w ? pwm_period_i : per_r;
        cmp_nxt = (valley_w && fifo_valid) ? fifo_q : cmp_r;
        if (valley_w) begin
            up_nxt = 1'b1;
            cnt_nxt = (pwm_period_i == 16'h0000) ? 16'h0000 : 16'h0001;
        end else if (up_r) begin
            if (cnt_r >= per_r) begin
                up_nxt = 1'b0;
                cnt_nxt = cnt_r - 16'h0001;
            end else begin
                cnt_nxt = cnt_r + 16'h0001;
            end
        end else begin
            cnt_nxt = cnt_r - 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cnt_r <= `SVM_RST_COUNT;
            per_r <= `SVM_RST_COUNT;
            up_r <= 1'b0;
            cmp_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            per_r <= per_nxt;
            up_r <= up_nxt;
            cmp_r <= cmp_nxt;
        end
    end

    // Sequencer
    svm_state_t state_r, state_nxt;
    logic run_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SVM_IDLE: if (start_i) state_nxt = SVM_START;
            SVM_START: if (stop_i) state_nxt = SVM_IDLE;
                else if (valley_w) state_nxt = SVM_RUN;
            SVM_RUN: if (stop_i) state_nxt = SVM_IDLE;
            SVM_FAULT: if (fault_clr_i && !fault_i) state_nxt = SVM_IDLE;
            default: state_nxt = SVM_FAULT;
        endcase
        if (fault_i) state_nxt = SVM_FAULT;
        run_nxt = (state_nxt == SVM_RUN);
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_r <= SVM_IDLE;
            pwm_en_o <= 1'b0;
            cur_pi_en_o <= 1'b0;
            spd_pi_en_o <= 1'b0;
            adc_trig_o <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pwm_en_o <= run_nxt;
            cur_pi_en_o <= run_nxt || state_nxt == SVM_START;
            spd_pi_en_o <= run_nxt;
            adc_trig_o <= valley_w && (state_r == SVM_START || state_r == SVM_RUN);
        end
    end

    assign state_o = state_r;

    // Gates with dead time
    logic [2:0] raw, raw_prev_r, raw_prev_nxt;
    logic [7:0] dt_r [3];
    logic [7:0] dt_nxt [3];
    svm_gate_t gate_nxt;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            raw[i] = cnt_r < cmp_r[i];
            if (raw[i] != raw_prev_r[i]) begin
                dt_nxt[i] = dead_time_i;
            end else if (dt_r[i] != 8'h00) begin
                dt_nxt[i] = dt_r[i] - 8'h01;
            end else begin
                dt_nxt[i] = 8'h00;
            end
            // Both sides held off while the leg's dead time runs
            gate_nxt.hi[i] = run_nxt && raw[i] && dt_nxt[i] == 8'h00;
            gate_nxt.lo[i] = run_nxt && !raw[i] && dt_nxt[i] == 8'h00;
        end
        raw_prev_nxt = raw;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            raw_prev_r <= 3'h0;
            gate_o <= '0;
            for (int i = 0; i < 3; i++) dt_r[i] <= `SVM_RST_DEAD;
        end else begin
            raw_prev_r <= raw_prev_nxt;
            gate_o <= gate_nxt;
            for (int i = 0; i < 3; i++) dt_r[i] <= dt_nxt[i];
        end
    end

    // Checks
    logic signed [16:0] dlo, dhi;
    assign dlo = 17'(vmin) - voff;
    assign dhi = 17'(vmax) - voff;

    property p_offset;
        @(posedge sys_clk_i) disable iff (rst_i)
        ph_valid_i |-> (dhi + dlo == 17'sh00000 || dhi + dlo == 17'sh00001);
    endproperty
    a_offset: assert property (p_offset) else $error("offset not mid of min and max");

    property p_inject;
        @(posedge sys_clk_i) disable iff (rst_i)
        (svm_en_i && ph_valid_i && vmax == ph_i.va && dhi > 17'sh00100 && dhi < 17'sh04000)
            |-> (17'(vsel[0]) > dhi);
    endproperty
    a_inject: assert property (p_inject) else $error("injection gain missing");

    property p_bypass;
        @(posedge sys_clk_i) disable iff (rst_i)
        !svm_en_i |-> (vsel[0] == ph_i.va && vsel[2] == ph_i.vc);
    endproperty
    a_bypass: assert property (p_bypass) else $error("sine mode altered phase");

    property p_scale;
        @(posedge sys_clk_i) disable iff (rst_i)
        (vsel[1] == 16'sh0000) |-> (duty_w[1] == {1'b0, pwm_period_i[15:1]});
    endproperty
    a_scale: assert property (p_scale) else $error("zero input not at half period");

    property p_carrier;
        @(posedge sys_clk_i) disable iff (rst_i)
        (up_r && cnt_r < per_r) |=> (cnt_r == $past(cnt_r) + 16'h0001);
    endproperty
    a_carrier: assert property (p_carrier) else $error("carrier did not count up");

    property p_no_shoot;
        @(posedge sys_clk_i) disable iff (rst_i)
        (gate_o.hi & gate_o.lo) == 3'h0;
    endproperty
    a_no_shoot: assert property (p_no_shoot) else $error("both switches of a leg on");

    sequence s_lo_off;
        !gate_o.lo[0] && gate_o.hi[0] == 1'b0;
    endsequence
    // Keyed on the loaded count, so a live change of dead_time_i cannot mislead it
    property p_dead;
        @(posedge sys_clk_i) disable iff (rst_i)
        ($fell(gate_o.lo[0]) && dt_r[0] == 8'h03 && pwm_en_o) |-> s_lo_off [*3];
    endproperty
    a_dead: assert property (p_dead) else $error("dead time too short");

    property p_compl;
        @(posedge sys_clk_i) disable iff (rst_i)
        (pwm_en_o && dt_r[2] == 8'h00) |-> (gate_o.hi[2] == !gate_o.lo[2]);
    endproperty
    a_compl: assert property (p_compl) else $error("leg outputs not complementary");

    property p_disable;
        @(posedge sys_clk_i) disable iff (rst_i)
        !run_nxt |=> (gate_o == '0 && !pwm_en_o);
    endproperty
    a_disable: assert property (p_disable) else $error("gates active after disable");

    property p_fault;
        @(posedge sys_clk_i) disable iff (rst_i)
        fault_i |=> (state_o == SVM_FAULT);
    endproperty
    a_fault: assert property (p_fault) else $error("fault not entered");

    sequence s_active_valley;
        valley_w && (state_r == SVM_RUN || state_r == SVM_START);
    endsequence
    property p_adc;
        @(posedge sys_clk_i) disable iff (rst_i)
        s_active_valley |=> adc_trig_o ##1 !adc_trig_o || valley_w;
    endproperty
    a_adc: assert property (p_adc) else $error("ADC trigger missing at valley");

endmodule // svm_pwm_modulator

// [verif/svm_inv_model.sv]
// Passive model of the three inverter legs: counts gate activity per leg.
// Assumes active-high gates sampled on sys_clk_i; clr_i restarts the counts.
`timescale 1ns/1ps
module svm_inv_model (
    input wire logic sys_clk_i,
    input wire logic clr_i,
    input wire svm_pkg::svm_gate_t gate_i,
    output logic [2:0][15:0] hi_cnt_o,
    output logic [2:0][15:0] gap_cnt_o,
    output logic shoot_o
);
    import svm_pkg::*;
    // A shoot-through latches, as a real leg would not survive it
    always @(posedge sys_clk_i) begin
        for (int i = 0; i < 3; i++) begin
            if (clr_i) begin
                hi_cnt_o[i] <= 16'h0000;
                gap_cnt_o[i] <= 16'h0000;
            end else begin
                hi_cnt_o[i] <= hi_cnt_o[i] + {15'h0000, gate_i.hi[i]};
                gap_cnt_o[i] <= gap_cnt_o[i] + {15'h0000, ~(gate_i.hi[i] | gate_i.lo[i])};
            end
        end
        if (clr_i)
            shoot_o <= 1'b0;
        else if (|(gate_i.hi & gate_i.lo))
            shoot_o <= 1'b1;
    end
endmodule // svm_inv_model

// [verif/svm_pwm_modulator_tb.sv]
// Self-checking bench for the space vector PWM modulator.
// Assumes the leg model above; short carrier period keeps the run brief.
`timescale 1ns/1ps
module svm_pwm_modulator_tb;
    import svm_pkg::*;
    localparam int P = 40;
    localparam int G = P * 1182 / 1024;
    localparam svm_phase_t SMP = '{va: 16'h2EE0, vb: 16'hF060, vc: 16'hE0C0};
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ph_valid = 1'b0;
    svm_phase_t ph = SMP;
    logic svm_en = 1'b1;
    logic [7:0] dt = 8'h00;
    logic start = 1'b0;
    logic stop = 1'b0;
    logic fault = 1'b0;
    logic fault_clr = 1'b0;
    logic inv_clr = 1'b1;
    logic ph_ready_o, adc_trig_o, pwm_en_o, cur_pi_en_o, spd_pi_en_o, shoot;
    svm_gate_t gate_o;
    svm_state_t state_o;
    logic [2:0][15:0] hi_cnt, gap_cnt;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;

    svm_pwm_modulator u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ph_valid_i(ph_valid),
        .ph_i(ph), .ph_ready_o(ph_ready_o), .svm_en_i(svm_en), .pwm_period_i(16'(P)),
        .pwm_gain_i(16'(G)), .dead_time_i(dt), .start_i(start), .stop_i(stop),
        .fault_i(fault), .fault_clr_i(fault_clr), .gate_o(gate_o), .adc_trig_o(adc_trig_o),
        .pwm_en_o(pwm_en_o), .cur_pi_en_o(cur_pi_en_o), .spd_pi_en_o(spd_pi_en_o),
        .state_o(state_o));
    svm_inv_model u_inv (.sys_clk_i(sys_clk_i), .clr_i(inv_clr), .gate_i(gate_o),
        .hi_cnt_o(hi_cnt), .gap_cnt_o(gap_cnt), .shoot_o(shoot));

    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("Counts: %0d checks, %0d mismatches", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under this many cycles
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 8000) begin
            bad_count++;
            final_report();
        end
    end

    // Expected scaled duty of one leg, worked out independently of the design
    function automatic logic [15:0] duty(input logic en, input int i);
        longint v[3];
        longint s, mn, mx;
        v[0] = $signed(SMP.va);
        v[1] = $signed(SMP.vb);
        v[2] = $signed(SMP.vc);
        mn = v[0] < v[1] ? v[0] : v[1];
        mn = mn < v[2] ? mn : v[2];
        mx = v[0] > v[1] ? v[0] : v[1];
        mx = mx > v[2] ? mx : v[2];
        s = v[i];
        if (en)
            s = (s - ((mn + mx) >>> 1)) * 37837 >>> 15;
        if (s > 32767)
            s = 32767;
        if (s < -32768)
            s = -32768;
        s = (longint'(P) * 32768 + ((longint'(G) * s) >>> 1)) >>> 16;
        if (s < 0)
            s = 0;
        if (s > P)
            s = P;
        return s[15:0];
    endfunction

    task automatic push(input svm_phase_t s);
        @(posedge sys_clk_i);
        ph <= s;
        ph_valid <= 1'b1;
        do @(posedge sys_clk_i); while (ph_ready_o !== 1'b1);
        ph_valid <= 1'b0;
    endtask

    task automatic t_reset();
        #1;
        check(gate_o, 6'h00);
        check(state_o, SVM_IDLE);
        check(pwm_en_o, 1'b0);
        check(ph_ready_o, 1'b1);
        $display("test reset done");
    endtask

    task automatic t_start();
        int n = 0;
        @(posedge sys_clk_i);
        start <= 1'b1;
        @(posedge sys_clk_i);
        start <= 1'b0;
        #1;
        check(state_o, SVM_START);
        check({cur_pi_en_o, pwm_en_o}, 2'h2);
        while (adc_trig_o !== 1'b1 && n < 4 * P) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        check(state_o, SVM_RUN);
        check({pwm_en_o, spd_pi_en_o, adc_trig_o}, 3'h7);
        @(posedge sys_clk_i);
        #1;
        check(adc_trig_o, 1'b0);
        $display("test start done");
    endtask

    // One full carrier period of gate activity per leg
    task automatic t_duty(input logic en, input logic [7:0] d);
        logic [15:0] c;
        @(posedge sys_clk_i);
        svm_en <= en;
        dt <= d;
        push(SMP);
        repeat (6 * P) @(posedge sys_clk_i);
        inv_clr <= 1'b1;
        @(posedge sys_clk_i);
        inv_clr <= 1'b0;
        repeat (2 * P) @(posedge sys_clk_i);
        #1;
        for (int i = 0; i < 3; i++) begin
            c = duty(en, i);
            if (d == 8'h00)
                check(hi_cnt[i], c == 0 ? 0 : 2 * c - 1);
            check(gap_cnt[i], 2 * d);
        end
        check(shoot, 1'b0);
        $display("test duty done");
    endtask

    task automatic t_fifo();
        int got = 0;
        int low = 0;
        @(posedge sys_clk_i);
        // Balanced sample puts leg b at zero, so its duty sits at half period
        ph <= '{va: 16'h1000, vb: 16'h0000, vc: 16'hF000};
        ph_valid <= 1'b1;
        repeat (12) begin
            @(posedge sys_clk_i);
            if (ph_ready_o === 1'b1)
                got++;
            else
                low++;
        end
        ph_valid <= 1'b0;
        check(low > 0, 1'b1);
        check(got >= 8 && got <= 9, 1'b1);
        repeat (22 * P) @(posedge sys_clk_i);
        #1;
        check(ph_ready_o, 1'b1);
        $display("test fifo done");
    endtask

    task automatic t_fault();
        @(posedge sys_clk_i);
        fault <= 1'b1;
        fault_clr <= 1'b1;
        @(posedge sys_clk_i);
        #1;
        check(state_o, SVM_FAULT);
        check(gate_o, 6'h00);
        check({pwm_en_o, cur_pi_en_o}, 2'h0);
        @(posedge sys_clk_i);
        fault <= 1'b0;
        #1;
        check(state_o, SVM_FAULT);
        @(posedge sys_clk_i);
        fault_clr <= 1'b0;
        #1;
        check(state_o, SVM_IDLE);
        $display("test fault done");
    endtask

    task automatic t_stop();
        @(posedge sys_clk_i);
        stop <= 1'b1;
        @(posedge sys_clk_i);
        stop <= 1'b0;
        #1;
        check(state_o, SVM_IDLE);
        check(gate_o, 6'h00);
        check({pwm_en_o, spd_pi_en_o}, 2'h0);
        $display("test stop done");
    endtask

    initial begin
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_start();
        t_duty(1'b1, 8'h00);
        t_duty(1'b0, 8'h00);
        t_duty(1'b1, 8'h03);
        t_fifo();
        t_fault();
        t_start();
        t_stop();
        final_report();
    end
endmodule // svm_pwm_modulator_tb
